// ===== shared/can_fault_regs.svh
// register offsets, field positions and thresholds of the fault and interrupt block
`ifndef CAN_FAULT_REGS_SVH
`define CAN_FAULT_REGS_SVH

`define ADDR_STATUS 8'h0E
`define ADDR_TX_COUNT 8'h1C
`define ADDR_RX_COUNT 8'h1D
`define ADDR_IRQ_ENABLE 8'h2B
`define ADDR_IRQ_FLAG 8'h2C
`define ADDR_FAULT_FLAGS 8'h2D

`define RST_BYTE 8'h00

`define SRC_RX0 0
`define SRC_RX1 1
`define SRC_TX0 2
`define SRC_TX1 3
`define SRC_TX2 4
`define SRC_ERR 5
`define SRC_WAK 6
`define SRC_MERR 7

`define IRQ_SOURCE_CODE_LSB 1

`define FF_ANY_WARN 0
`define FF_RX_WARN 1
`define FF_TX_WARN 2
`define FF_RX_PASSIVE 3
`define FF_TX_PASSIVE 4
`define FF_BUS_OFF 5
`define FF_OVF0 6
`define FF_OVF1 7
`define FF_HOST_MASK 8'hC0

`define WARN_LIMIT 8'h60
`define PASSIVE_LIMIT 8'h80
`define COUNT_TOP 8'hFF
`define RX_RELOAD 8'h77
`define RECOV_SEQS 8'h80
`define RECOV_LAST 8'h7F

`endif

// ===== shared/can_fault_pkg.sv
// types of the fault tracking and interrupt block
package can_fault_pkg;

  typedef enum logic [1:0] {
    MODE_ACTIVE,
    MODE_PASSIVE,
    MODE_BUS_OFF
  } fault_mode_t;

  typedef struct packed {
    logic [7:0] count;
  } tally_state_t;

  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] flags;
    logic [1:0] ovf;
    logic bus_off;
    logic [5:0] last_state;
    logic [7:0] recov_cnt;
    fault_mode_t mode;
    logic [7:0] rdata;
    logic wake;
  } core_state_t;

endpackage

// ===== src/fault_tally.sv
// saturating 8-bit error counter with the CAN step sizes
`timescale 1ns/1ps
`include "can_fault_regs.svh"
module fault_tally import can_fault_pkg::*; #(
  parameter bit HIGH_RELOAD = 1'b0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // steps
  input wire logic inc1,
  input wire logic inc8,
  input wire logic dec,
  input wire logic clr,
  // result
  output logic [7:0] count,
  output logic at_top
);
  tally_state_t s_ff;
  tally_state_t nxt_s;
  logic [8:0] sum;

  always_comb
  begin
    nxt_s = s_ff;
    sum = {1'b0, s_ff.count} + (inc8 ? 9'h008 : 9'h000) + (inc1 ? 9'h001 : 9'h000);
    if (clr)
    begin
      nxt_s.count = `RST_BYTE;
    end
    else if (inc1 || inc8)
    begin
      // saturate: the top value is what signals bus-off
      nxt_s.count = sum[8] ? `COUNT_TOP : sum[7:0];
    end
    else if (dec && (s_ff.count != `RST_BYTE))
    begin
      if (HIGH_RELOAD && (s_ff.count >= `PASSIVE_LIMIT))
        nxt_s.count = `RX_RELOAD;
      else
        nxt_s.count = s_ff.count - 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign count = s_ff.count;
  assign at_top = (s_ff.count == `COUNT_TOP);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_saturate;
    (inc8 && !clr && s_ff.count > 8'hF7) |=> (count == `COUNT_TOP);
  endproperty
  a_saturate: assert property (p_saturate) else $error("tally did not saturate");
endmodule // fault_tally

// ===== src/irq_prio.sv
// priority encoder for the interrupt source code
`timescale 1ns/1ps
`include "can_fault_regs.svh"
module irq_prio (
  // enabled and pending sources
  input wire logic [7:0] pending,
  // lowest nonzero code wins
  output logic [2:0] code
);
  always_comb
  begin
    code = 3'h0;
    if (pending[`SRC_ERR])
      code = 3'h1;
    else if (pending[`SRC_WAK])
      code = 3'h2;
    else if (pending[`SRC_TX0])
      code = 3'h3;
    else if (pending[`SRC_TX1])
      code = 3'h4;
    else if (pending[`SRC_TX2])
      code = 3'h5;
    else if (pending[`SRC_RX0])
      code = 3'h6;
    else if (pending[`SRC_RX1])
      code = 3'h7;
  end
endmodule // irq_prio

// ===== src/can_fault_irq_logic.sv
// error counters, fault flags, interrupt flags and source code of the CAN controller
`timescale 1ns/1ps
`include "can_fault_regs.svh"
module can_fault_irq_logic import can_fault_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register access from the serial command engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_wmask,
  output logic [7:0] reg_rdata,
  // protocol engine events, one-cycle pulses
  input wire logic tx_err,
  input wire logic tx_ok,
  input wire logic rx_err,
  input wire logic rx_err_heavy,
  input wire logic rx_ok,
  input wire logic msg_error,
  input wire logic [2:0] tx_empty,
  input wire logic [1:0] rx_loaded,
  input wire logic recessive_run,
  input wire logic bus_activity,
  // sleep handling
  input wire logic asleep,
  output logic wake_req,
  // host interrupt and fault state
  output logic int_n,
  output logic bus_off,
  output logic error_passive
);
  core_state_t s_ff;
  core_state_t nxt_s;
  logic [7:0] outbound_fault_tally;
  logic [7:0] inbound_fault_tally;
  logic tx_top;
  logic recov_done;
  logic counting;
  logic [7:0] pending;
  logic [2:0] irq_source_code;
  logic tx_warning_flag;
  logic rx_warning_flag;
  logic any_warning_flag;
  logic tx_passive_flag;
  logic rx_passive_flag;
  logic [5:0] live_state;
  logic [7:0] set_evt;
  logic [7:0] hold;
  logic [7:0] written;
  logic [1:0] ovf_set;
  logic [1:0] ovf_wr;
  logic err_evt;
  logic [7:0] fault_state_flags;
  logic [7:0] controller_status_reg;

  // counters freeze while bus-off and restart from zero after recovery
  assign counting = !s_ff.bus_off;
  assign recov_done = s_ff.bus_off && recessive_run && (s_ff.recov_cnt == `RECOV_LAST);

  fault_tally #(
    .HIGH_RELOAD(1'b0)
  ) u_tx_tally (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .inc1(1'b0),
    .inc8(tx_err && counting),
    .dec(tx_ok && counting),
    .clr(recov_done),
    .count(outbound_fault_tally),
    .at_top(tx_top)
  );

  fault_tally #(
    .HIGH_RELOAD(1'b1)
  ) u_rx_tally (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .inc1(rx_err && !rx_err_heavy && counting),
    .inc8(rx_err_heavy && counting),
    .dec(rx_ok && counting),
    .clr(recov_done),
    .count(inbound_fault_tally),
    .at_top()
  );

  assign tx_warning_flag = (outbound_fault_tally >= `WARN_LIMIT);
  assign rx_warning_flag = (inbound_fault_tally >= `WARN_LIMIT);
  assign any_warning_flag = tx_warning_flag || rx_warning_flag;
  assign tx_passive_flag = (outbound_fault_tally >= `PASSIVE_LIMIT);
  assign rx_passive_flag = (inbound_fault_tally >= `PASSIVE_LIMIT);

  assign pending = s_ff.flags & s_ff.enable;

  irq_prio u_prio (
    .pending(pending),
    .code(irq_source_code)
  );

  assign fault_state_flags = {s_ff.ovf, s_ff.bus_off, tx_passive_flag, rx_passive_flag,
    tx_warning_flag, rx_warning_flag, any_warning_flag};
  assign controller_status_reg = {4'h0, irq_source_code, 1'b0};

  always_comb
  begin
    nxt_s = s_ff;
    live_state = {s_ff.bus_off, tx_passive_flag, rx_passive_flag,
      tx_warning_flag, rx_warning_flag, any_warning_flag};
    ovf_set = 2'h0;
    ovf_wr = s_ff.ovf;
    written = s_ff.flags;
    set_evt = 8'h00;
    hold = 8'h00;

    // bus-off entry and recovery
    if (s_ff.bus_off)
    begin
      if (recov_done)
      begin
        nxt_s.bus_off = 1'b0;
        nxt_s.recov_cnt = `RST_BYTE;
      end
      else if (recessive_run)
      begin
        nxt_s.recov_cnt = s_ff.recov_cnt + 8'h01;
      end
    end
    else if (tx_top)
    begin
      nxt_s.bus_off = 1'b1;
      nxt_s.recov_cnt = `RST_BYTE;
    end

    if (nxt_s.bus_off)
      nxt_s.mode = MODE_BUS_OFF;
    else if (tx_passive_flag || rx_passive_flag)
      nxt_s.mode = MODE_PASSIVE;
    else
      nxt_s.mode = MODE_ACTIVE;

    // overflow: a message arrives while its buffer flag is still pending
    ovf_set = rx_loaded & s_ff.flags[`SRC_RX1:`SRC_RX0];

    // hardware events
    set_evt[`SRC_RX0] = rx_loaded[0];
    set_evt[`SRC_RX1] = rx_loaded[1];
    set_evt[`SRC_TX2:`SRC_TX0] = tx_empty;
    set_evt[`SRC_MERR] = msg_error;
    set_evt[`SRC_WAK] = asleep && bus_activity;
    // only a bit going from clear to set counts, not a repeat overflow
    err_evt = (|(ovf_set & ~s_ff.ovf)) || (live_state != s_ff.last_state);
    set_evt[`SRC_ERR] = err_evt;
    nxt_s.last_state = live_state;

    // a cause still present keeps its flag against a host clear
    hold = set_evt;
    hold[`SRC_ERR] = err_evt || (|s_ff.ovf);

    if (reg_wr)
    begin
      if (reg_addr == `ADDR_IRQ_ENABLE)
      begin
        nxt_s.enable = (s_ff.enable & ~reg_wmask) | (reg_wdata & reg_wmask);
      end
      else if (reg_addr == `ADDR_IRQ_FLAG)
      begin
        // masked write lets the host touch only chosen flags
        written = (s_ff.flags & ~reg_wmask) | (reg_wdata & reg_wmask);
      end
      else if (reg_addr == `ADDR_FAULT_FLAGS)
      begin
        ovf_wr = (s_ff.ovf & ~reg_wmask[`FF_OVF1:`FF_OVF0])
          | (reg_wdata[`FF_OVF1:`FF_OVF0] & reg_wmask[`FF_OVF1:`FF_OVF0]);
      end
    end

    // set wins over a clear arriving in the same cycle
    nxt_s.flags = written | (s_ff.flags & hold) | set_evt;
    nxt_s.ovf = ovf_wr | ovf_set;

    // waking needs the enable; the flag alone does not end sleep
    nxt_s.wake = asleep && bus_activity && s_ff.enable[`SRC_WAK];

    if (reg_rd)
    begin
      if (reg_addr == `ADDR_TX_COUNT)
        nxt_s.rdata = outbound_fault_tally;
      else if (reg_addr == `ADDR_RX_COUNT)
        nxt_s.rdata = inbound_fault_tally;
      else if (reg_addr == `ADDR_FAULT_FLAGS)
        nxt_s.rdata = fault_state_flags;
      else if (reg_addr == `ADDR_IRQ_ENABLE)
        nxt_s.rdata = s_ff.enable;
      else if (reg_addr == `ADDR_IRQ_FLAG)
        nxt_s.rdata = s_ff.flags;
      else if (reg_addr == `ADDR_STATUS)
        nxt_s.rdata = controller_status_reg;
      else
        nxt_s.rdata = `RST_BYTE;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_ff <= '0;
      s_ff.mode <= MODE_ACTIVE;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign int_n = !(|pending);
  assign reg_rdata = s_ff.rdata;
  assign wake_req = s_ff.wake;
  assign bus_off = s_ff.bus_off;
  assign error_passive = (s_ff.mode != MODE_ACTIVE);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_host_sets_enabled;
    reg_wr && reg_addr == `ADDR_IRQ_FLAG && (reg_wdata & reg_wmask & s_ff.enable) != 8'h00;
  endsequence

  sequence s_recovery_end;
    s_ff.bus_off && recessive_run && s_ff.recov_cnt == `RECOV_LAST;
  endsequence

  property p_int_pending;
    (|(s_ff.flags & s_ff.enable)) |-> !int_n;
  endproperty
  a_int_pending: assert property (p_int_pending) else $error("interrupt not asserted");

  property p_host_set;
    s_host_sets_enabled |=> !int_n;
  endproperty
  a_host_set: assert property (p_host_set) else $error("host-set flag gave no interrupt");

  property p_hold_clear;
    (reg_wr && reg_addr == `ADDR_IRQ_FLAG && reg_wmask[`SRC_TX0] && !reg_wdata[`SRC_TX0]
      && tx_empty[0]) |=> s_ff.flags[`SRC_TX0];
  endproperty
  a_hold_clear: assert property (p_hold_clear) else $error("flag cleared while cause held");

  property p_code_none;
    (s_ff.enable & s_ff.flags) == 8'h00 |-> irq_source_code == 3'h0;
  endproperty
  a_code_none: assert property (p_code_none) else $error("code nonzero with nothing pending");

  property p_code_err;
    (s_ff.enable[`SRC_ERR] && s_ff.flags[`SRC_ERR]) |-> irq_source_code == 3'h1;
  endproperty
  a_code_err: assert property (p_code_err) else $error("error source not top priority");

  property p_code_masked;
    !s_ff.enable[`SRC_RX1] |-> irq_source_code != 3'h7;
  endproperty
  a_code_masked: assert property (p_code_masked) else $error("disabled source in code");

  property p_rx_flag;
    rx_loaded[1] |=> s_ff.flags[`SRC_RX1] ##1 (s_ff.flags[`SRC_RX1] || $past(reg_wr));
  endproperty
  a_rx_flag: assert property (p_rx_flag) else $error("receive flag lost");

  property p_msg_fault;
    msg_error |=> s_ff.flags[`SRC_MERR];
  endproperty
  a_msg_fault: assert property (p_msg_fault) else $error("message fault flag not set");

  property p_wake;
    (asleep && bus_activity && s_ff.enable[`SRC_WAK]) |=> wake_req && s_ff.flags[`SRC_WAK];
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup not raised");

  property p_overflow;
    (rx_loaded[0] && s_ff.flags[`SRC_RX0]) |=> s_ff.ovf[0] ##1 s_ff.flags[`SRC_ERR];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_state_change;
    $rose(tx_passive_flag) |=> s_ff.flags[`SRC_ERR];
  endproperty
  a_state_change: assert property (p_state_change) else $error("state change missed");

  property p_bus_off_entry;
    (!s_ff.bus_off && tx_top) |=> s_ff.bus_off;
  endproperty
  a_bus_off_entry: assert property (p_bus_off_entry) else $error("bus-off not entered");

  property p_recovery;
    s_recovery_end |=> !s_ff.bus_off && outbound_fault_tally == 8'h00;
  endproperty
  a_recovery: assert property (p_recovery) else $error("recovery did not complete");

  property p_frozen;
    (s_ff.bus_off && !recov_done) |=> $stable(outbound_fault_tally) && $stable(inbound_fault_tally);
  endproperty
  a_frozen: assert property (p_frozen) else $error("counter moved while bus-off");

  property p_passive_out;
    (tx_passive_flag || rx_passive_flag) |=> error_passive;
  endproperty
  a_passive_out: assert property (p_passive_out) else $error("passive state not shown");

  property p_pending_code;
    (|pending[`SRC_WAK:`SRC_RX0]) |-> irq_source_code != 3'h0;
  endproperty
  a_pending_code: assert property (p_pending_code) else $error("pending source gave no code");

  property p_ovf_keep;
    (s_ff.ovf[1] && !(reg_wr && reg_addr == `ADDR_FAULT_FLAGS)) |=> s_ff.ovf[1];
  endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow bit lost");

  property p_wake_masked;
    (asleep && bus_activity && !s_ff.enable[`SRC_WAK]) |=> !wake_req && s_ff.flags[`SRC_WAK];
  endproperty
  a_wake_masked: assert property (p_wake_masked) else $error("masked wakeup misbehaved");
endmodule // can_fault_irq_logic

// ===== verif/host_model.sv
// host side model: drives the register command port of the fault block
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic sys_clk,
  // register command port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic [7:0] reg_wmask
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wmask = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wmask <= m;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // masked clear, so a flag set during the write is not lost
  task automatic clr(input logic [7:0] a, input logic [7:0] bits);
    wr(a, 8'h00, bits);
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask
endmodule // host_model

// ===== verif/tb_top.sv
// self-checking bench of the fault counters and interrupt block
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [12:0] ev = '0;
  logic asleep = 1'b0;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_wmask;
  logic [7:0] reg_rdata;
  logic wake_req;
  logic int_n;
  logic bus_off;
  logic error_passive;
  int err_total = 0;
  int n_compared = 0;
  logic [7:0] exp_q [$];
  logic rd_d = 1'b0;
  logic [7:0] f;
  logic [7:0] e;
  int k;
  int src [7] = '{5, 6, 2, 3, 4, 0, 1};
  logic [7:0] ev_flag [6] = '{8'h80, 8'h04, 8'h08, 8'h10, 8'h01, 8'h02};

  always #25 sys_clk = ~sys_clk;

  host_model i_host (
    .sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wmask(reg_wmask)
  );

  can_fault_irq_logic i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wmask(reg_wmask),
    .reg_rdata(reg_rdata), .tx_err(ev[0]), .tx_ok(ev[1]), .rx_err(ev[2]),
    .rx_err_heavy(ev[3]), .rx_ok(ev[4]), .msg_error(ev[5]), .tx_empty(ev[8:6]),
    .rx_loaded(ev[10:9]), .recessive_run(ev[11]), .bus_activity(ev[12]),
    .asleep(asleep), .wake_req(wake_req), .int_n(int_n), .bus_off(bus_off),
    .error_passive(error_passive)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    i_host.rd(a);
  endtask

  // event pulses held high for n sampling edges
  task automatic pulse(input logic [12:0] v, input int n);
    @(posedge sys_clk);
    ev <= v;
    repeat (n) @(posedge sys_clk);
    ev <= '0;
  endtask

  // lowest code among enabled pending sources wins
  function automatic logic [7:0] stat_of(input logic [7:0] p);
    stat_of = 8'h00;
    for (int i = 6; i >= 0; i--)
      if (p[src[i]])
        stat_of = 8'(i + 1) << 1;
  endfunction

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // read data is valid one cycle after the strobe edge
  always @(posedge sys_clk)
  begin
    rd_d <= reg_rd;
    if (rd_d && exp_q.size() > 0)
      chk(reg_rdata, exp_q.pop_front());
  end

  initial
  begin
    void'($urandom(32'h479991C4));
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(8'h1C, 8'h00);
    rd(8'h1D, 8'h00);
    rd(8'h2D, 8'h00);
    rd(8'h2C, 8'h00);
    rd(8'h55, 8'h00);
    i_host.wr(8'h1C, 8'hFF, 8'hFF);
    rd(8'h1C, 8'h00);
    #1 chk({7'h00, int_n}, 8'h01);
    $display("test reset_values done");
    for (k = 0; k < 16; k++)
    begin
      f = (k < 7) ? 8'(1 << src[k % 7]) : 8'($urandom);
      e = (k < 7) ? 8'hFF : 8'($urandom);
      i_host.wr(8'h2B, e, 8'hFF);
      i_host.wr(8'h2C, f, 8'hFF);
      #1 chk({7'h00, int_n}, {7'h00, ~|(f & e)});
      rd(8'h0E, stat_of(f & e));
      rd(8'h2C, f);
    end
    i_host.clr(8'h2C, 8'hFF);
    i_host.wr(8'h2B, 8'hFF, 8'hFF);
    $display("test priority done");
    for (k = 0; k < 6; k++)
    begin
      pulse(13'h0020 << k, 1);
      #1 chk({7'h00, int_n}, 8'h00);
      rd(8'h2C, ev_flag[k]);
      i_host.clr(8'h2C, 8'hFF);
      #1 chk({7'h00, int_n}, 8'h01);
    end
    pulse(13'h0040, 1);
    fork
      i_host.clr(8'h2C, 8'h04);
      pulse(13'h0040, 1);
    join
    rd(8'h2C, 8'h04);
    i_host.clr(8'h2C, 8'h04);
    rd(8'h2C, 8'h00);
    @(posedge sys_clk);
    asleep <= 1'b1;
    pulse(13'h1000, 1);
    k = 0;
    #1;
    while (wake_req !== 1'b1 && k < 4)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk({7'h00, wake_req}, 8'h01);
    if (k == 4)
      complete_run();
    asleep <= 1'b0;
    rd(8'h2C, 8'h40);
    i_host.clr(8'h2C, 8'hFF);
    i_host.wr(8'h2B, 8'h3F, 8'hFF);
    asleep <= 1'b1;
    pulse(13'h1020, 1);
    #1 chk({6'h00, wake_req, int_n}, 8'h01);
    asleep <= 1'b0;
    rd(8'h2C, 8'hC0);
    i_host.clr(8'h2C, 8'hFF);
    i_host.wr(8'h2B, 8'hFF, 8'hFF);
    $display("test events done");
    pulse(13'h0200, 1);
    pulse(13'h0200, 1);
    rd(8'h2D, 8'h40);
    rd(8'h2C, 8'h21);
    i_host.clr(8'h2C, 8'h20);
    rd(8'h2C, 8'h21);
    i_host.clr(8'h2D, 8'h40);
    i_host.clr(8'h2C, 8'hFF);
    rd(8'h2D, 8'h00);
    rd(8'h2C, 8'h00);
    $display("test overflow done");
    pulse(13'h0004, 12);
    rd(8'h1D, 8'h0C);
    pulse(13'h0008, 1);
    rd(8'h1D, 8'h14);
    pulse(13'h0004, 76);
    rd(8'h1D, 8'h60);
    rd(8'h2D, 8'h03);
    rd(8'h2C, 8'h20);
    pulse(13'h0004, 32);
    rd(8'h2D, 8'h0B);
    chk({7'h00, error_passive}, 8'h01);
    pulse(13'h0010, 1);
    rd(8'h1D, 8'h77);
    rd(8'h2D, 8'h03);
    i_host.clr(8'h2C, 8'hFF);
    pulse(13'h0001, 12);
    rd(8'h1C, 8'h60);
    rd(8'h2D, 8'h07);
    rd(8'h2C, 8'h20);
    pulse(13'h0002, 1);
    rd(8'h1C, 8'h5F);
    rd(8'h2D, 8'h03);
    pulse(13'h0001, 21);
    rd(8'h1C, 8'hFF);
    rd(8'h2D, 8'h37);
    chk({7'h00, bus_off}, 8'h01);
    pulse(13'h0800, 127);
    #1 chk({7'h00, bus_off}, 8'h01);
    pulse(13'h0800, 1);
    repeat (2) @(posedge sys_clk);
    #1 chk({7'h00, bus_off}, 8'h00);
    rd(8'h1C, 8'h00);
    rd(8'h1D, 8'h00);
    rd(8'h2D, 8'h00);
    chk({7'h00, error_passive}, 8'h00);
    $display("test counters done");
    repeat (3) @(posedge sys_clk);
    chk(8'(exp_q.size()), 8'h00);
    complete_run();
  end
endmodule // tb_top
